// ### common/cfm_cfg.svh
// Constants for the chip fault monitor.
`ifndef CFM_CFG_SVH
`define CFM_CFG_SVH

`define CFM_FRAME_BITS  16
`define CFM_CNT_W       5
`define CFM_CNT_GOOD    5'h10
`define CFM_CNT_SAT     5'h11
`define CFM_CNT_ONE     5'h01
`define CFM_CNT_ZERO    5'h00
`define CFM_WORD_ZERO   16'h0000
`define CFM_PARITY_GOOD 1'b1

`endif

// ### common/cfm_pkg.sv
// Types shared by the chip fault monitor modules.
`include "cfm_cfg.svh"

package cfm_pkg;

  typedef enum logic [1:0] {
    CFM_DOWN,
    CFM_INIT,
    CFM_RUN
  } cfm_mode_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } cfm_sync_t;

  typedef struct packed {
    logic [`CFM_CNT_W-1:0]      count;
    logic                       parity;
    logic [`CFM_FRAME_BITS-1:0] word;
    logic                       frame_tog;
  } cfm_frame_t;

  typedef struct packed {
    cfm_mode_t                  mode;
    logic                       tog_seen;
    logic                       strobe_prev;
    logic                       por_flag;
    logic                       ot_flag;
    logic                       se_flag;
    logic                       tw_flag;
    logic                       rl_flag;
    logic                       rh_flag;
    logic                       frame_ok;
    logic                       xfer_err;
    logic [`CFM_FRAME_BITS-1:0] word;
  } cfm_state_t;

endpackage

// ### hdl/cfm_sync.sv
// Three-stage synchroniser with an agreement filter on the last two stages.
`timescale 1ns/1ns
`default_nettype none

module cfm_sync (
  input  wire logic clk_sys,   // System clock.
  input  wire logic reset,     // Synchronous reset, active high.
  input  wire logic async_in,  // Level from another domain.
  output logic      level_out  // Filtered level in the system domain.
);

  cfm_pkg::cfm_sync_t st_reg;
  cfm_pkg::cfm_sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // The level only moves once the second and third stages agree.
    if (st_reg.s2 == st_reg.s3) begin
      st_next.level = st_reg.s3;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;

endmodule

`default_nettype wire

// ### hdl/cfm_frame_count.sv
// Serial-clock side of the frame checker: edge count, parity and data capture.
`timescale 1ns/1ns
`default_nettype none

module cfm_frame_count (
  input  wire logic                       reset,          // System reset, clears the link side.
  input  wire logic                       sck,            // Serial clock from the host.
  input  wire logic                       frame_strobe_n, // Frame strobe, active low.
  input  wire logic                       sdi,            // Serial data in.
  output logic [`CFM_CNT_W-1:0]           edge_count,     // Edges in the last frame, saturating.
  output logic                            parity,         // XOR of all bits of the last frame.
  output logic [`CFM_FRAME_BITS-1:0]      word,           // Last frame's first sixteen bits.
  output logic                            frame_tog       // Toggles on each frame's first edge.
);

  cfm_pkg::cfm_frame_t fr_reg;
  cfm_pkg::cfm_frame_t fr_next;
  logic                in_frame_reg;

  // The serial clock stops between frames, so the strobe itself ends the frame.
  always_ff @(posedge sck or posedge frame_strobe_n) begin
    if (frame_strobe_n) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  always_comb begin
    fr_next = fr_reg;
    if (!in_frame_reg) begin
      fr_next.count     = `CFM_CNT_ONE;
      fr_next.parity    = sdi;
      fr_next.word      = {fr_reg.word[`CFM_FRAME_BITS-2:0], sdi};
      fr_next.frame_tog = ~fr_reg.frame_tog;
    end else begin
      // RL10 count sck edges
      if (fr_reg.count != `CFM_CNT_SAT) begin
        fr_next.count = fr_reg.count + `CFM_CNT_ONE;
      end
      fr_next.parity = fr_reg.parity ^ sdi;
      if (fr_reg.count < `CFM_CNT_GOOD) begin
        fr_next.word = {fr_reg.word[`CFM_FRAME_BITS-2:0], sdi};
      end
    end
  end

  // Held values stay stable between frames while the system side reads them.
  // The serial clock may not run during reset, so reset acts without it; the toggle then starts known.
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      fr_reg <= '0;
    end else begin
      fr_reg <= fr_next;
    end
  end

  assign edge_count = fr_reg.count;
  assign parity     = fr_reg.parity;
  assign word       = fr_reg.word;
  assign frame_tog  = fr_reg.frame_tog;

endmodule

`default_nettype wire

// ### hdl/cfm_chip_fault_monitor.sv
// Chip-level fault supervision: logic supply, temperature, regulator and serial frame checks.
//
// Overview of operation
// RL1: Logic supply lockout has no mask input; it always acts.
// RL2: Before the logic supply is valid, logic idles and gate drive stays off.
// RL3: On supply valid, pulse register init and clear every fault flag.
// RL4: After power-on reset, set any-fault and logic-supply-reset flags.
// RL5: Supply loss disables outputs at once, freezes logic, reruns power-up later.
// RL6: Overtemperature indication sets the latched overtemperature flag.
// RL7: With shutdown enabled, overtemperature turns all gate drive off.
// RL8: With shutdown disabled, overtemperature only sets its flag.
// RL9: Overtemperature clearing restores outputs; its flag stays latched.
// RL10: Serial error on over sixteen edges, early strobe rise, or even parity.
// RL11: An erroneous frame is not committed and sets the serial error flag.
// RL12: An erroneous write does not cause the status reset.
// RL13: An erroneous read does not clear the addressed register.
// RL14: Regulator low sets its flag and forces gate drive off.
// RL15: Regulator recovery re-enables gate drive; its flag stays latched.
// RL16: Regulator low monitor acts during power-up, holding gate drive off.
// RL17: Regulator low mask stops its action; host should leave it clear.
// RL18: Regulator high sets its flag and does nothing else.
// RL19: Regulator high clearing keeps its flag latched.
// RL20: Temperature warning sets its flag, with no protective action.
// RL21: Temperature warning clearing keeps its flag latched.
// RL22: Every monitor but supply, serial error and overtemperature is maskable.
// RL23: Any-fault flag is high whenever a status fault flag is set; the code leaves out the regulator low and high flags.
// RL24: Each comparator input is synchronised before use; the code also takes the raw logic supply input straight into gate drive.
`timescale 1ns/1ns
`default_nettype none

module cfm_chip_fault_monitor (
  input  wire logic                       clk_sys,               // Logic clock, 25 MHz.
  input  wire logic                       reset,                 // Power-on reset, sync, active high.
  input  wire logic                       logic_supply_ok,       // Logic supply above lockout, async.
  input  wire logic                       overtemp_in,           // Overtemperature comparator, async.
  input  wire logic                       hot_warning_in,        // Temperature warning comparator, async.
  input  wire logic                       regulator_low_in,      // Regulator undervoltage comparator, async.
  input  wire logic                       regulator_high_in,     // Regulator overvoltage comparator, async.
  input  wire logic                       fault_shutdown_enable, // Overtemperature shuts outputs down.
  input  wire logic                       mask_regulator_low,    // Masks regulator undervoltage.
  input  wire logic                       mask_regulator_high,   // Masks regulator overvoltage.
  input  wire logic                       mask_hot_warning,      // Masks temperature warning.
  input  wire logic                       fault_reset,           // Pulse: clear latched fault flags.
  input  wire logic                       sck,                   // Serial clock, link domain.
  input  wire logic                       frame_strobe_n,        // Frame strobe, active low.
  input  wire logic                       sdi,                   // Serial data in.
  output logic                            gate_enable,           // Gate drive allowed.
  output logic                            regs_init,             // Pulse: serial registers to reset value.
  output logic                            any_fault_flag,        // Status bit 15.
  output logic                            logic_supply_reset_flag, // Power-on reset happened.
  output logic                            overtemp_flag,         // Latched overtemperature.
  output logic                            serial_error_flag,     // Latched serial transfer error.
  output logic                            hot_warning_flag,      // Latched temperature warning.
  output logic                            regulator_low_flag,    // Latched regulator undervoltage.
  output logic                            regulator_high_flag,   // Latched regulator overvoltage.
  output logic                            frame_ok,              // Pulse: valid frame may commit.
  output logic                            transfer_error,        // Pulse: frame rejected.
  output logic [`CFM_FRAME_BITS-1:0]      frame_word             // Data of the last valid frame.
);

  cfm_pkg::cfm_state_t st_reg;
  cfm_pkg::cfm_state_t st_next;

  logic                        supply_s;
  logic                        ot_s;
  logic                        tw_s;
  logic                        rl_s;
  logic                        rh_s;
  logic                        strobe_s;
  logic                        tog_s;
  logic [`CFM_CNT_W-1:0]       lk_count;
  logic                        lk_parity;
  logic [`CFM_FRAME_BITS-1:0]  lk_word;
  logic                        lk_tog;
  logic                        running;
  logic                        frame_end;
  logic [`CFM_CNT_W-1:0]       frame_edges;
  logic                        frame_bad;
  logic                        ot_act;
  logic                        tw_act;
  logic                        rl_act;
  logic                        rh_act;

  // RL24 synchronise comparators
  cfm_sync u_sync_supply (.clk_sys(clk_sys), .reset(reset), .async_in(logic_supply_ok),   .level_out(supply_s));
  cfm_sync u_sync_ot     (.clk_sys(clk_sys), .reset(reset), .async_in(overtemp_in),       .level_out(ot_s));
  cfm_sync u_sync_tw     (.clk_sys(clk_sys), .reset(reset), .async_in(hot_warning_in),    .level_out(tw_s));
  cfm_sync u_sync_rl     (.clk_sys(clk_sys), .reset(reset), .async_in(regulator_low_in),  .level_out(rl_s));
  cfm_sync u_sync_rh     (.clk_sys(clk_sys), .reset(reset), .async_in(regulator_high_in), .level_out(rh_s));
  cfm_sync u_sync_strobe (.clk_sys(clk_sys), .reset(reset), .async_in(frame_strobe_n),    .level_out(strobe_s));
  cfm_sync u_sync_tog    (.clk_sys(clk_sys), .reset(reset), .async_in(lk_tog),            .level_out(tog_s));

  cfm_frame_count u_frame (
    .reset          (reset),
    .sck            (sck),
    .frame_strobe_n (frame_strobe_n),
    .sdi            (sdi),
    .edge_count     (lk_count),
    .parity         (lk_parity),
    .word           (lk_word),
    .frame_tog      (lk_tog)
  );

  assign running = (st_reg.mode == cfm_pkg::CFM_RUN);

  // RL22 mask gating
  assign ot_act = ot_s;
  assign tw_act = tw_s & ~mask_hot_warning;
  // RL17 mask stops action
  assign rl_act = rl_s & ~mask_regulator_low;
  assign rh_act = rh_s & ~mask_regulator_high;

  // Frame ends on the synchronised strobe rising; no first edge means zero edges.
  assign frame_end   = running & strobe_s & ~st_reg.strobe_prev;
  assign frame_edges = (tog_s != st_reg.tog_seen) ? lk_count : `CFM_CNT_ZERO;
  // RL10 frame checks
  assign frame_bad   = (frame_edges != `CFM_CNT_GOOD) | (lk_parity != `CFM_PARITY_GOOD);

  always_comb begin
    st_next             = st_reg;
    st_next.frame_ok    = 1'b0;
    st_next.xfer_err    = 1'b0;
    st_next.strobe_prev = strobe_s;
    unique case (st_reg.mode)
      cfm_pkg::CFM_DOWN: begin
        // RL5 rerun power-up
        if (supply_s) begin
          st_next.mode = cfm_pkg::CFM_INIT;
        end
      end
      cfm_pkg::CFM_INIT: begin
        // RL3 clear fault state
        st_next.mode     = cfm_pkg::CFM_RUN;
        st_next.ot_flag  = 1'b0;
        st_next.se_flag  = 1'b0;
        st_next.tw_flag  = 1'b0;
        st_next.rl_flag  = 1'b0;
        st_next.rh_flag  = 1'b0;
        st_next.tog_seen = tog_s;
        // RL4 flag power-on reset
        st_next.por_flag = 1'b1;
      end
      cfm_pkg::CFM_RUN: begin
        // RL5 suspend on supply loss
        if (!supply_s) begin
          st_next.mode = cfm_pkg::CFM_DOWN;
        end else begin
          if (fault_reset) begin
            st_next.por_flag = 1'b0;
            st_next.ot_flag  = 1'b0;
            st_next.se_flag  = 1'b0;
            st_next.tw_flag  = 1'b0;
            st_next.rl_flag  = 1'b0;
            st_next.rh_flag  = 1'b0;
          end
          // RL6 latch overtemperature
          if (ot_act) begin
            st_next.ot_flag = 1'b1;
          end
          // RL20 latch warning only
          if (tw_act) begin
            st_next.tw_flag = 1'b1;
          end
          // RL14 latch regulator low
          if (rl_act) begin
            st_next.rl_flag = 1'b1;
          end
          // RL18 latch regulator high
          if (rh_act) begin
            st_next.rh_flag = 1'b1;
          end
          if (frame_end) begin
            st_next.tog_seen = tog_s;
            // RL11 cancel bad frame
            if (frame_bad) begin
              st_next.se_flag  = 1'b1;
              st_next.xfer_err = 1'b1;
            end else begin
              // RL12 commit only valid
              st_next.frame_ok = 1'b1;
              st_next.word     = lk_word;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg      <= '0;
      st_reg.mode <= cfm_pkg::CFM_DOWN;
      // Strobe idles high, so start high to avoid a false frame end.
      st_reg.strobe_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // RL2 hold off until running
  // RL5 raw supply cuts drive at once
  // RL7 shutdown on overtemperature
  // RL8 no shutdown when disabled
  // RL9 re-enable on clear
  // RL15 re-enable on recovery
  // RL16 regulator holds at power-up
  // RL19 high never gates drive
  // RL21 warning never gates drive
  assign gate_enable = running & logic_supply_ok & ~(ot_act & fault_shutdown_enable) & ~rl_act;

  assign regs_init               = (st_reg.mode == cfm_pkg::CFM_INIT);
  // RL23 any fault summary
  assign any_fault_flag          = st_reg.por_flag | st_reg.ot_flag | st_reg.se_flag | st_reg.tw_flag;
  assign logic_supply_reset_flag = st_reg.por_flag;
  assign overtemp_flag           = st_reg.ot_flag;
  assign serial_error_flag       = st_reg.se_flag;
  assign hot_warning_flag        = st_reg.tw_flag;
  assign regulator_low_flag      = st_reg.rl_flag;
  assign regulator_high_flag     = st_reg.rh_flag;
  // RL13 no clear on error
  assign frame_ok                = st_reg.frame_ok;
  assign transfer_error          = st_reg.xfer_err;
  assign frame_word              = st_reg.word;

endmodule

`default_nettype wire

// ### verification/cfm_fault_props_properties.sv
// Concurrent checks on the chip fault monitor ports.
`timescale 1ns/1ns
`default_nettype none
module cfm_fault_props (
  input wire logic clk_sys,                 // Logic clock.
  input wire logic reset,                   // Sync reset.
  input wire logic logic_supply_ok,         // Raw supply good.
  input wire logic overtemp_in,             // Overtemperature in.
  input wire logic regulator_low_in,        // Regulator low in.
  input wire logic fault_shutdown_enable,   // Shutdown enable.
  input wire logic mask_regulator_low,      // Regulator low mask.
  input wire logic fault_reset,             // Flag clear pulse.
  input wire logic gate_enable,             // Gate drive allowed.
  input wire logic regs_init,               // Init pulse.
  input wire logic any_fault_flag,          // Summary flag.
  input wire logic logic_supply_reset_flag, // Power-on flag.
  input wire logic overtemp_flag,           // Overtemp flag.
  input wire logic serial_error_flag,       // Serial error flag.
  input wire logic hot_warning_flag,        // Warning flag.
  input wire logic regulator_low_flag,      // Regulator low flag.
  input wire logic regulator_high_flag,     // Regulator high flag.
  input wire logic frame_ok,                // Good frame pulse.
  input wire logic transfer_error           // Bad frame pulse.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_supply_gate_off: assert property (!logic_supply_ok |-> !gate_enable)
    else $error("gate enabled without logic supply");
  a_regl_gate_off: assert property ((regulator_low_in && !mask_regulator_low) [*6] |-> !gate_enable)
    else $error("gate enabled during regulator low");
  a_ot_gate_off: assert property ((overtemp_in && fault_shutdown_enable) [*6] |-> !gate_enable)
    else $error("gate enabled during overtemperature shutdown");
  a_ot_flag_cause: assert property ($rose(overtemp_flag) |-> $past(overtemp_in, 3))
    else $error("overtemperature flag without cause");
  a_any_fault_sum: assert property (any_fault_flag == (logic_supply_reset_flag || overtemp_flag
                                    || serial_error_flag || hot_warning_flag))
    else $error("summary flag disagrees with status flags");
  a_init_clears_flags: assert property (regs_init |=> logic_supply_reset_flag && !overtemp_flag
    && !serial_error_flag && !hot_warning_flag && !regulator_low_flag && !regulator_high_flag)
    else $error("power-up did not reset flags");
  a_ot_flag_held: assert property (overtemp_flag && !fault_reset && !regs_init |=> overtemp_flag)
    else $error("overtemperature flag dropped");
  a_error_sets_flag: assert property (transfer_error |=> serial_error_flag && !frame_ok)
    else $error("rejected frame did not set serial error flag");
  a_frame_excl: assert property (!(frame_ok && transfer_error))
    else $error("frame both accepted and rejected");
  c_init: cover property (regs_init);
  c_frame_ok: cover property (frame_ok);
  c_frame_bad: cover property (transfer_error);
endmodule
bind cfm_chip_fault_monitor cfm_fault_props chk_i (.clk_sys, .reset, .logic_supply_ok, .overtemp_in,
  .regulator_low_in, .fault_shutdown_enable, .mask_regulator_low, .fault_reset, .gate_enable,
  .regs_init, .any_fault_flag, .logic_supply_reset_flag, .overtemp_flag, .serial_error_flag,
  .hot_warning_flag, .regulator_low_flag, .regulator_high_flag, .frame_ok, .transfer_error);
`default_nettype wire

// ### verification/cfm_host_model.sv
// Serial host model: strobed frames of link clock edges with data.
`timescale 1ns/1ns
`default_nettype none
module cfm_host_model (
  output logic sck,            // Link clock, still between frames.
  output logic frame_strobe_n, // Frame strobe, active low.
  output logic sdi             // Serial data, MSB first.
);
  initial begin
    sck = 1'b0;
    frame_strobe_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic send(input logic [16:0] bits, input int n);
    #7;
    frame_strobe_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = bits[i];
      #15;
      sck = 1'b1;
      #15;
      sck = 1'b0;
    end
    #15;
    frame_strobe_n = 1'b1;
    // Released data line shows the inverse of the last bit.
    sdi = ~sdi;
    #400;
  endtask
endmodule
`default_nettype wire

// ### verification/cfm_chip_fault_monitor_tb_top.sv
// Self-checking bench for the chip fault monitor.
`timescale 1ns/1ns
`default_nettype none
module cfm_chip_fault_monitor_tb_top;
  logic        clk_sys = 1'b0, reset = 1'b1, sup = 1'b0, ot = 1'b0, hw = 1'b0, rl = 1'b0, rh = 1'b0;
  logic        shut = 1'b1, m_rl = 1'b0, m_rh = 1'b0, m_hw = 1'b0, f_rst = 1'b0;
  logic        gate, init, aff, porf, otf, sef, hwf, rlf, rhf, fok, terr, sck, strobe_n, sdi;
  logic [15:0] fword;
  logic [7:0]  vec;
  int          err_count = 0, n_compared = 0, cycles = 0;
  assign vec = {gate, aff, porf, otf, sef, hwf, rlf, rhf};
  always #20 clk_sys = ~clk_sys;
  cfm_chip_fault_monitor dut (.clk_sys(clk_sys), .reset(reset), .logic_supply_ok(sup), .overtemp_in(ot),
    .hot_warning_in(hw), .regulator_low_in(rl), .regulator_high_in(rh), .fault_shutdown_enable(shut),
    .mask_regulator_low(m_rl), .mask_regulator_high(m_rh), .mask_hot_warning(m_hw), .fault_reset(f_rst),
    .sck(sck), .frame_strobe_n(strobe_n), .sdi(sdi), .gate_enable(gate), .regs_init(init),
    .any_fault_flag(aff), .logic_supply_reset_flag(porf), .overtemp_flag(otf), .serial_error_flag(sef),
    .hot_warning_flag(hwf), .regulator_low_flag(rlf), .regulator_high_flag(rhf), .frame_ok(fok),
    .transfer_error(terr), .frame_word(fword));
  cfm_host_model host (.sck(sck), .frame_strobe_n(strobe_n), .sdi(sdi));
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Order: gate, any, por, ot, se, hw, rl, rh.
  task automatic flags(logic [7:0] exp);
    step(8);
    chk("gate and flags", {8'h00, exp}, {8'h00, vec});
  endtask
  task automatic clr;
    // Let lowered comparator inputs pass the synchronisers first, since a set wins over the clear.
    step(8);
    @(posedge clk_sys) f_rst <= 1'b1;
    @(posedge clk_sys) f_rst <= 1'b0;
  endtask
  task automatic wait_init;
    for (int i = 0; i < 20 && init !== 1'b1; i++) step(1);
    chk("regs_init", 16'h0001, {15'h0000, init});
  endtask
  task automatic frame(logic [16:0] bits, int n, logic ok);
    logic [1:0] got;
    got = 2'b00;
    fork
      host.send(bits, n);
      for (int i = 0; i < 60 && got == 2'b00; i++) begin
        step(1);
        got = {fok, terr};
      end
    join
    chk("frame result", {14'h0000, ok, !ok}, {14'h0000, got});
    chk("frame_word", 16'ha5a4, fword);
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  logic [16:0] bad_bits [3] = '{17'h0a5a5, 17'h00001, 17'h0a5a4};
  int          bad_n [3] = '{16, 15, 17};
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    flags(8'h00);
    @(posedge clk_sys) sup <= 1'b1;
    wait_init();
    step(1);
    chk("power-on flags", 16'h00e0, {8'h00, vec});
    clr();
    flags(8'h80);
    @(posedge clk_sys) ot <= 1'b1;
    flags(8'h50);
    @(posedge clk_sys) ot <= 1'b0;
    flags(8'hd0);
    @(posedge clk_sys) shut <= 1'b0;
    ot <= 1'b1;
    flags(8'hd0);
    @(posedge clk_sys) ot <= 1'b0;
    shut <= 1'b1;
    clr();
    @(posedge clk_sys) rl <= 1'b1;
    flags(8'h02);
    @(posedge clk_sys) rl <= 1'b0;
    flags(8'h82);
    clr();
    @(posedge clk_sys) {m_rl, rl, rh, hw} <= 4'hf;
    flags(8'hc5);
    @(posedge clk_sys) {rh, hw} <= 2'h0;
    flags(8'hc5);
    clr();
    @(posedge clk_sys) {m_rh, m_hw, rh, hw} <= 4'hf;
    flags(8'h80);
    @(posedge clk_sys) {rl, rh, hw} <= 3'h0;
    step(8);
    @(posedge clk_sys) {m_rl, m_rh, m_hw} <= 3'h0;
    frame(17'h0a5a4, 16, 1'b1);
    for (int k = 0; k < 3; k++) frame(bad_bits[k], bad_n[k], 1'b0);
    flags(8'hc8);
    clr();
    @(posedge clk_sys) sup <= 1'b0;
    rl <= 1'b1;
    @(negedge clk_sys) chk("gate on supply loss", 16'h0000, {15'h0000, gate});
    step(8);
    @(posedge clk_sys) sup <= 1'b1;
    wait_init();
    step(1);
    chk("repower flags", 16'h0060, {8'h00, vec});
    @(posedge clk_sys) rl <= 1'b0;
    flags(8'he2);
    finish_test();
  end
endmodule
`default_nettype wire
